// ==== hw/timer_pkg.sv ====
// Summary of operation
// - Two timers, each with 16-bit read/write register.
// - Writing a timer loads its count immediately.
// - First decrement on second selected tick edge.
// - Reaching zero raises that timer's interrupt.
// - Counters may be read at any time.
// - PLL mode offers 512 kHz and 2 kHz.
// - External mode offers 541 kHz and 2.115 kHz.
// - In external mode, bit 12 selects divide-by-26 500 kHz tick.
// - 500 kHz selection leaves peripheral tick unchanged.
// - Standby state stops both counters.
// - Free running or prescale mode, software selected.
// - Free running wraps to 0xffff on underflow.
// - Prescale reloads last written value on underflow.
// - Prescale gives periodic tick, first timer drives buzzer.
package timer_pkg;

    // ************************************************************
    // Clock rates and tick sources.
    // ************************************************************
    localparam int unsigned PCLK_HZ     = 10_000_000;
    localparam int unsigned PLL_FAST_HZ = 512_000;
    localparam int unsigned PLL_SLOW_HZ = 2_000;
    localparam int unsigned EXT_SRC_HZ  = 13_000_000;
    localparam int unsigned EXT_FAST_HZ = 541_000;
    localparam int unsigned EXT_SLOW_HZ = 2_115;
    localparam int unsigned OS_DIVIDE   = 26;
    localparam int unsigned OS_TICK_HZ  = EXT_SRC_HZ / OS_DIVIDE;
    localparam int unsigned ACC_W       = 24;
    localparam int unsigned NUM_TICKS   = 5;
    localparam int unsigned TICK_PLL_FAST = 0;
    localparam int unsigned TICK_PLL_SLOW = 1;
    localparam int unsigned TICK_EXT_FAST = 2;
    localparam int unsigned TICK_EXT_SLOW = 3;
    localparam int unsigned TICK_OS       = 4;

    // ************************************************************
    // Register offsets (byte addresses on the bus).
    // ************************************************************
    localparam logic [7:0] ADDR_FIRST_TIMER  = 8'h00;
    localparam logic [7:0] ADDR_SECOND_TIMER = 8'h04;
    localparam logic [7:0] ADDR_SYS_CTRL     = 8'h08;
    localparam logic [7:0] ADDR_SYS_CTRL2    = 8'h0c;
    localparam logic [7:0] ADDR_INT_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_INT_CLEAR    = 8'h14;
    localparam logic [7:0] ADDR_INT_ENABLE   = 8'h18;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int unsigned FIRST_MODE_BIT  = 0;
    localparam int unsigned FIRST_CLK_BIT   = 1;
    localparam int unsigned SECOND_MODE_BIT = 2;
    localparam int unsigned SECOND_CLK_BIT  = 3;
    localparam int unsigned OS_TICK_BIT     = 12;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] WRAP_VALUE      = 16'hffff;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;

    // Tick step added to a rate accumulator every pclk cycle.
    localparam logic [ACC_W-1:0] STEP_PLL_FAST = ACC_W'(PLL_FAST_HZ);
    localparam logic [ACC_W-1:0] STEP_PLL_SLOW = ACC_W'(PLL_SLOW_HZ);
    localparam logic [ACC_W-1:0] STEP_EXT_FAST = ACC_W'(EXT_FAST_HZ);
    localparam logic [ACC_W-1:0] STEP_EXT_SLOW = ACC_W'(EXT_SLOW_HZ);
    localparam logic [ACC_W-1:0] STEP_OS       = ACC_W'(OS_TICK_HZ);
    localparam logic [ACC_W-1:0] ACC_WRAP      = ACC_W'(PCLK_HZ);

endpackage

// ==== hw/dual_down_counter_timers.sv ====
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
module dual_down_counter_timers (
    // APB clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave port.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // System state pins.
    input  wire logic        clock_from_pll,
    input  wire logic        standby_state,
    // Outputs to the rest of the chip.
    output logic             irq,
    output logic             buzzer,
    output logic             periph_fast_tick
);

    // ************************************************************
    // State of the block.
    // ************************************************************
    typedef struct packed {
        logic                                      pll_meta;
        logic                                      pll_sync;
        logic                                      stby_meta;
        logic                                      stby_sync;
        logic [timer_pkg::NUM_TICKS-1:0][timer_pkg::ACC_W-1:0] acc;
        logic [1:0][15:0]                          count;
        logic [1:0][15:0]                          reload;
        logic [1:0]                                armed;
        logic [3:0]                                ctrl;
        logic                                      os_tick_divide_select;
        logic [1:0]                                status;
        logic [1:0]                                enable;
        logic [31:0]                               rdata;
        logic                                      ready;
        logic                                      err;
        logic                                      irq;
        logic                                      buzzer;
        logic                                      periph_tick;
    } state_s;

    state_s cur;
    state_s next_cur;

    // ************************************************************
    // Helper functions.
    // ************************************************************

    // Advances a rate accumulator; the top bit of the result is the tick.
    function automatic logic [timer_pkg::ACC_W:0] rate_step(
        input logic [timer_pkg::ACC_W-1:0] acc,
        input logic [timer_pkg::ACC_W-1:0] step
    );
        logic [timer_pkg::ACC_W-1:0] sum;
        sum = acc + step;
        if (sum >= timer_pkg::ACC_WRAP) begin
            rate_step = {1'b1, sum - timer_pkg::ACC_WRAP};
        end else begin
            rate_step = {1'b0, sum};
        end
    endfunction

    // Returns the step of one tick source.
    function automatic logic [timer_pkg::ACC_W-1:0] tick_step(input int unsigned idx);
        case (idx)
            timer_pkg::TICK_PLL_FAST: tick_step = timer_pkg::STEP_PLL_FAST;
            timer_pkg::TICK_PLL_SLOW: tick_step = timer_pkg::STEP_PLL_SLOW;
            timer_pkg::TICK_EXT_FAST: tick_step = timer_pkg::STEP_EXT_FAST;
            timer_pkg::TICK_EXT_SLOW: tick_step = timer_pkg::STEP_EXT_SLOW;
            default:                  tick_step = timer_pkg::STEP_OS;
        endcase
    endfunction

    // ************************************************************
    // Next-state logic.
    // ************************************************************

    // Computes the complete next state of the block.
    always_comb begin
        logic [timer_pkg::NUM_TICKS-1:0] tick;
        logic [timer_pkg::ACC_W:0]       stepped;
        logic                            fast_tick;
        logic                            slow_tick;
        logic [1:0]                      timer_tick;
        logic [1:0]                      mode_prescale;
        logic [1:0]                      clk_slow;
        logic [1:0]                      underflow;
        logic [1:0]                      clear_bits;
        logic                            setup;
        logic                            wr_take;
        tick          = '0;
        stepped       = '0;
        fast_tick     = 1'b0;
        slow_tick     = 1'b0;
        timer_tick    = 2'h0;
        underflow     = 2'h0;
        clear_bits    = 2'h0;
        mode_prescale = 2'h0;
        clk_slow      = 2'h0;
        setup         = 1'b0;
        wr_take       = 1'b0;
        next_cur      = cur;

        // Two-stage synchronisers for the state pins.
        next_cur.pll_meta  = clock_from_pll;
        next_cur.pll_sync  = cur.pll_meta;
        next_cur.stby_meta = standby_state;
        next_cur.stby_sync = cur.stby_meta;

        // All tick sources run from fractional rate accumulators.
        for (int unsigned i = 0; i < timer_pkg::NUM_TICKS; i++) begin
            stepped         = rate_step(cur.acc[i], tick_step(i));
            tick[i]         = stepped[timer_pkg::ACC_W];
            next_cur.acc[i] = stepped[timer_pkg::ACC_W-1:0];
        end

        // Fast and slow timer taps from the PLL or the external source.
        if (cur.pll_sync) begin
            fast_tick = tick[timer_pkg::TICK_PLL_FAST];
            slow_tick = tick[timer_pkg::TICK_PLL_SLOW];
        end else begin
            if (cur.os_tick_divide_select) begin
                fast_tick = tick[timer_pkg::TICK_OS];
            end else begin
                fast_tick = tick[timer_pkg::TICK_EXT_FAST];
            end
            slow_tick = tick[timer_pkg::TICK_EXT_SLOW];
        end

        // Peripheral tick ignores the divide select on purpose.
        next_cur.periph_tick = cur.pll_sync ? tick[timer_pkg::TICK_PLL_FAST]
                                            : tick[timer_pkg::TICK_EXT_FAST];

        // Per-timer mode and clock bits.
        mode_prescale[0] = cur.ctrl[timer_pkg::FIRST_MODE_BIT];
        mode_prescale[1] = cur.ctrl[timer_pkg::SECOND_MODE_BIT];
        clk_slow[0]      = cur.ctrl[timer_pkg::FIRST_CLK_BIT];
        clk_slow[1]      = cur.ctrl[timer_pkg::SECOND_CLK_BIT];

        // Counting on the selected tick, held off in standby.
        for (int t = 0; t < 2; t++) begin
            timer_tick[t] = (clk_slow[t] ? slow_tick : fast_tick) & ~cur.stby_sync;
            if (timer_tick[t]) begin
                if (!cur.armed[t]) begin
                    next_cur.armed[t] = 1'b1;
                end else if (cur.count[t] == 16'h0000) begin
                    if (mode_prescale[t]) begin
                        next_cur.count[t] = cur.reload[t];
                    end else begin
                        next_cur.count[t] = timer_pkg::WRAP_VALUE;
                    end
                end else begin
                    next_cur.count[t] = cur.count[t] - 16'h0001;
                    underflow[t]      = (cur.count[t] == 16'h0001);
                end
            end
        end

        // APB phases.
        setup   = psel & ~penable;
        wr_take = psel & penable & cur.ready & pwrite;

        // Register writes take effect at the completing edge.
        if (wr_take) begin
            case (paddr)
                timer_pkg::ADDR_FIRST_TIMER: begin
                    next_cur.count[0]  = pwdata[15:0];
                    next_cur.reload[0] = pwdata[15:0];
                    next_cur.armed[0]  = 1'b0;
                    underflow[0]       = 1'b0;
                end
                timer_pkg::ADDR_SECOND_TIMER: begin
                    next_cur.count[1]  = pwdata[15:0];
                    next_cur.reload[1] = pwdata[15:0];
                    next_cur.armed[1]  = 1'b0;
                    underflow[1]       = 1'b0;
                end
                timer_pkg::ADDR_SYS_CTRL: begin
                    next_cur.ctrl = pwdata[3:0];
                end
                timer_pkg::ADDR_SYS_CTRL2: begin
                    next_cur.os_tick_divide_select = pwdata[timer_pkg::OS_TICK_BIT];
                end
                timer_pkg::ADDR_INT_CLEAR: begin
                    clear_bits = pwdata[1:0];
                end
                timer_pkg::ADDR_INT_ENABLE: begin
                    next_cur.enable = pwdata[1:0];
                end
                default: begin
                    next_cur.enable = next_cur.enable;
                end
            endcase
        end

        // Sticky interrupt status; a new underflow beats a clear.
        next_cur.status = (cur.status & ~clear_bits) | underflow;
        next_cur.irq    = |(next_cur.status & next_cur.enable);

        // Buzzer toggles on each first-timer underflow.
        if (underflow[0]) begin
            next_cur.buzzer = ~cur.buzzer;
        end

        // Zero-wait answer: ready and the refusal flag stand for the access phase only.
        next_cur.ready = setup;
        next_cur.err   = 1'b0;
        if (setup) begin
            next_cur.rdata = 32'h0000_0000;
            case (paddr)
                timer_pkg::ADDR_FIRST_TIMER:  next_cur.rdata[15:0] = cur.count[0];
                timer_pkg::ADDR_SECOND_TIMER: next_cur.rdata[15:0] = cur.count[1];
                timer_pkg::ADDR_SYS_CTRL:     next_cur.rdata[3:0]  = cur.ctrl;
                timer_pkg::ADDR_SYS_CTRL2: begin
                    next_cur.rdata[timer_pkg::OS_TICK_BIT] = cur.os_tick_divide_select;
                end
                timer_pkg::ADDR_INT_STATUS:   next_cur.rdata[1:0]  = cur.status;
                timer_pkg::ADDR_INT_CLEAR:    next_cur.rdata[1:0]  = 2'h0;
                timer_pkg::ADDR_INT_ENABLE:   next_cur.rdata[1:0]  = cur.enable;
                default: begin
                    next_cur.err = 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************

    // Registers the whole state; reset gives constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur                       <= '0;
            cur.count                 <= {timer_pkg::COUNT_RESET, timer_pkg::COUNT_RESET};
            cur.reload                <= {timer_pkg::COUNT_RESET, timer_pkg::COUNT_RESET};
            cur.ctrl                  <= timer_pkg::CTRL_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ************************************************************
    // Outputs straight from the state register.
    // ************************************************************

    // Drives the ports from their flip-flops.
    assign prdata           = cur.rdata;
    assign pready           = cur.ready;
    assign pslverr          = cur.err;
    assign irq              = cur.irq;
    assign buzzer           = cur.buzzer;
    assign periph_fast_tick = cur.periph_tick;

endmodule // dual_down_counter_timers

// ==== test/dual_down_counter_timers_assertions.sv ====
`timescale 1ns/10ps
// ************************************************************
// Port checks for the dual timer block.
// ************************************************************
module dual_down_counter_timers_checker (
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus side.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and outputs.
    input wire logic        clock_from_pll,
    input wire logic        standby_state,
    input wire logic        irq,
    input wire logic        buzzer,
    input wire logic        periph_fast_tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The bus answers once, one cycle after each setup, with clean error data.
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready stayed high for a second cycle.");
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("No answer in the cycle after a setup.");
    a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready rose without a setup before it.");
    a_err_unmapped: assert property (pready && paddr > 8'h18 |-> pslverr)
        else $error("Unmapped access was not refused.");
    a_err_mapped: assert property (pready && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("Mapped access was refused.");
    a_err_data_zero: assert property (pslverr |-> prdata == 32'h00000000)
        else $error("Refused read returned nonzero data.");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("Upper read bits are not zero.");

    // Masking, standby and tick spacing.
    a_irq_masked: assert property (pready && psel && penable && pwrite && paddr == 8'h18
        && pwdata[1:0] == 2'b00 |=> ##1 !irq)
        else $error("Interrupt stayed high with all enables cleared.");
    a_buzzer_frozen: assert property (standby_state [*6] |-> $stable(buzzer))
        else $error("Buzzer moved during standby.");
    a_tick_spacing: assert property (periph_fast_tick |=> !periph_fast_tick [*8])
        else $error("Peripheral tick pulses too close together.");
endmodule // dual_down_counter_timers_checker

// ==== test/tb_dual_down_counter_timers.sv ====
`timescale 1ns/10ps
module tb_dual_down_counter_timers;
    logic        pclk, presetn, psel, penable, pwrite, clock_from_pll, standby_state, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic        pready, pslverr, irq, buzzer, periph_fast_tick, b0;
    int          mismatches = 0, checks = 0, seed = 90, pulses = 0, n0, k, i;
    int          lo[3] = '{795, 783, 799};
    int          hi[3] = '{798, 786, 802};
    int          plo[3] = '{203, 215, 215};
    int          phi[3] = '{206, 218, 218};

    dual_down_counter_timers DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clock_from_pll(clock_from_pll),
        .standby_state(standby_state), .irq(irq), .buzzer(buzzer),
        .periph_fast_tick(periph_fast_tick));

    // ************************************************************
    // Clock, tick counter, watchdog and shared tasks.
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Counts peripheral tick pulses where they are settled.
    always @(negedge pclk) if (periph_fast_tick === 1'b1) pulses <= pulses + 1;
    // Cuts a hang short.
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        conclude();
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer; the request holds until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && w < 20) begin @(posedge pclk); w++; end
        if (w >= 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic wait_pulse;
        @(negedge pclk);
        while (periph_fast_tick !== 1'b1) @(negedge pclk);
    endtask
    task automatic wait_irq;
        k = 0;
        @(negedge pclk);
        while (irq !== 1'b1 && k < 20000) begin @(negedge pclk); k++; end
        if (k >= 20000) mismatches++;
        // Lets the pulse counter settle before anyone reads it.
        @(posedge pclk);
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        {psel, penable, pwrite, presetn, standby_state} = 5'h00;
        paddr = 8'h00; pwdata = 32'h0; clock_from_pll = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i <= 24; i += 4) rdc(8'(i), 32'h0);
        rdc(8'h1c, 32'h0);
        check(err, 1'b1);
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            apb(1'b1, 8'(4 * (i % 2)), d);
            rdc(8'(4 * (i % 2)), {16'h0, d[15:0]});
        end
        apb(1'b1, 8'h10, 32'h3);
        rdc(8'h10, 32'h0);
        standby_state <= 1'b1;
        apb(1'b1, 8'h00, 32'h10);
        repeat (200) @(posedge pclk);
        rdc(8'h00, 32'h10);
        standby_state <= 1'b0;
        // Free running: arming tick, underflow, wrap, then mask and clear.
        apb(1'b1, 8'h18, 32'h1);
        b0 = buzzer;
        wait_pulse();
        apb(1'b1, 8'h00, 32'h3);
        n0 = pulses;
        wait_irq();
        check(pulses - n0, 4);
        check(buzzer, !b0);
        wait_pulse();
        rdc(8'h00, 32'hffff);
        rdc(8'h10, 32'h1);
        apb(1'b1, 8'h18, 32'h0);
        repeat (2) @(negedge pclk);
        check(irq, 1'b0);
        apb(1'b1, 8'h18, 32'h1);
        repeat (2) @(negedge pclk);
        check(irq, 1'b1);
        apb(1'b1, 8'h14, 32'h1);
        rdc(8'h10, 32'h0);
        // Prescale: reload of the written value and periodic underflow.
        apb(1'b1, 8'h08, 32'h1);
        wait_pulse();
        apb(1'b1, 8'h00, 32'h3);
        wait_irq();
        apb(1'b1, 8'h14, 32'h1);
        n0 = pulses;
        wait_irq();
        check(pulses - n0, 4);
        wait_pulse();
        rdc(8'h00, 32'h3);
        // Second timer on the slow tap while the first keeps its mode.
        apb(1'b1, 8'h18, 32'h2);
        apb(1'b1, 8'h08, 32'h9);
        apb(1'b1, 8'h04, 32'h2);
        repeat (1000) @(posedge pclk);
        rdc(8'h04, 32'h2);
        wait_irq();
        check(k inside {[8900:14200]}, 1'b1);
        // Fast tap rates for the three clock setups.
        apb(1'b1, 8'h18, 32'h0);
        apb(1'b1, 8'h08, 32'h0);
        for (i = 0; i < 3; i++) begin
            clock_from_pll <= (i == 0);
            apb(1'b1, 8'h0c, (i == 2) ? 32'h1000 : 32'h0);
            apb(1'b1, 8'h04, 32'd1000);
            n0 = pulses;
            repeat (4000) @(posedge pclk);
            apb(1'b0, 8'h04, 32'h0);
            check(rd[15:0] inside {[lo[i]:hi[i]]}, 1'b1);
            check((pulses - n0) inside {[plo[i]:phi[i]]}, 1'b1);
        end
        conclude();
    end
endmodule // tb_dual_down_counter_timers

bind dual_down_counter_timers dual_down_counter_timers_checker u_checker (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_from_pll(clock_from_pll), .standby_state(standby_state), .irq(irq),
    .buzzer(buzzer), .periph_fast_tick(periph_fast_tick));
